// file: core/tlel_core.sv
/*
 * Temperature reading, limit compare and open-drain alert logic with an
 * AXI4-Lite register slave. Assumes one clock, a synchronous active-low
 * reset, and a sampler delivering readings as single-cycle valid pulses.
 */
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps

module tlel_core (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Sampler side
   input wire tlel_pkg::tlel_sample_t sample,
   output logic conv_enable,
   // Open-drain alert pin
   input wire logic alert_in,
   output tlel_pkg::tlel_pin_t alert_pin
);
   import tlel_pkg::*;

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   // Host-visible registers
   logic [15:0] config_reg;
   logic [15:0] high_limit;
   logic [15:0] low_limit;
   logic [15:0] critical_limit;

   // Latest reading, its status bits and width
   logic [12:0] temp_value;
   logic [2:0] temp_flags;
   logic [1:0] resolution_capability;

   // Last evaluated limit states
   logic above_high;
   logic below_low;
   logic above_crit;

   // Event record, alert level, pending work
   logic event_latch;
   logic clear_pending;
   logic alert_state;
   logic eval_pending;
   logic alert_in_q;

   // AXI write side holding registers
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;

   // Byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                           input logic [3:0] strb);
      merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
   endfunction

   // Address is one of the mapped registers
   function automatic logic is_mapped(input logic [7:0] addr);
      is_mapped = (addr == TLEL_OFS_CONFIG) || (addr == TLEL_OFS_HIGH) || (addr == TLEL_OFS_LOW) ||
                  (addr == TLEL_OFS_CRIT) || (addr == TLEL_OFS_TEMP) || (addr == TLEL_OFS_CAPAB);
   endfunction

   // ---------------------------------------------------------------
   // Write channel decode
   // ---------------------------------------------------------------
   // Address and data may arrive in either order; the write fires once both are held
   wire do_write = aw_held && w_held && !bvalid;
   wire wr_config = do_write && (aw_addr_q == TLEL_OFS_CONFIG);
   wire wr_high = do_write && (aw_addr_q == TLEL_OFS_HIGH);
   wire wr_low = do_write && (aw_addr_q == TLEL_OFS_LOW);
   wire wr_crit = do_write && (aw_addr_q == TLEL_OFS_CRIT);
   wire wr_capab = do_write && (aw_addr_q == TLEL_OFS_CAPAB);

   // Locks are set-only and hold until reset
   wire alarm_lock = config_reg[TLEL_CFG_ALARM_LOCK];
   wire crit_lock = config_reg[TLEL_CFG_CRIT_LOCK];
   wire any_lock = alarm_lock || crit_lock;

   // Write data merged per byte lane
   wire [15:0] cfg_in = merge16(config_reg, w_data_q, w_strb_q);
   wire [15:0] limit_high_in = merge16(high_limit, w_data_q, w_strb_q) & TLEL_LIMIT_MASK;
   wire [15:0] limit_low_in = merge16(low_limit, w_data_q, w_strb_q) & TLEL_LIMIT_MASK;
   wire [15:0] limit_crit_in = merge16(critical_limit, w_data_q, w_strb_q) & TLEL_LIMIT_MASK;

   // Locked limit drops the write, still OKAY
   wire alarm_wr_ok = (wr_high || wr_low) && !alarm_lock;
   wire crit_wr_ok = wr_crit && !crit_lock;

   // Ready while the holding register is free
   assign awready = !aw_held;
   assign wready = !w_held;
   assign arready = !rvalid;

   // Locked fields keep their value; locks are set-only; shutdown cannot be entered while locked
   logic [15:0] next_config;
   always_comb begin
      next_config = config_reg;
      if (wr_config) begin
         next_config[10:9] = cfg_in[10:9];
         next_config[3:0] = cfg_in[3:0];
         if (any_lock) begin
            next_config = (next_config & ~TLEL_CFG_LOCKED_MASK) | (config_reg & TLEL_CFG_LOCKED_MASK);
         end
         if (alarm_lock && cfg_in[TLEL_CFG_CRIT_ONLY]) begin
            next_config[TLEL_CFG_CRIT_ONLY] = config_reg[TLEL_CFG_CRIT_ONLY];
         end
         next_config[TLEL_CFG_ALARM_LOCK] = alarm_lock || cfg_in[TLEL_CFG_ALARM_LOCK];
         next_config[TLEL_CFG_CRIT_LOCK] = crit_lock || cfg_in[TLEL_CFG_CRIT_LOCK];
         next_config[TLEL_CFG_SHUTDOWN] = cfg_in[TLEL_CFG_SHUTDOWN] && (config_reg[TLEL_CFG_SHUTDOWN] || !any_lock);
      end
      next_config[15:11] = 5'h00;
      next_config[TLEL_CFG_CLEAR] = 1'b0;
      next_config[TLEL_CFG_STS] = 1'b0;
   end

   // ---------------------------------------------------------------
   // AXI handshake registers
   // ---------------------------------------------------------------
   // Each channel taken alone; response waits for both
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         bvalid <= 1'b0;
         bresp <= TLEL_RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_held <= 1'b1;
            aw_addr_q <= awaddr;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
         if (wvalid && wready) begin
            w_held <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
         if (do_write) begin
            bvalid <= 1'b1;
            bresp <= is_mapped(aw_addr_q) ? TLEL_RESP_OKAY : TLEL_RESP_SLVERR;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   // Limits move only on an accepted, unlocked write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         config_reg <= TLEL_CFG_RESET;
         high_limit <= TLEL_LIMIT_RESET;
         low_limit <= TLEL_LIMIT_RESET;
         critical_limit <= TLEL_LIMIT_RESET;
         resolution_capability <= TLEL_RES_RESET;
      end else begin
         config_reg <= next_config;
         if (alarm_wr_ok && wr_high) begin
            high_limit <= limit_high_in;
         end
         if (alarm_wr_ok && wr_low) begin
            low_limit <= limit_low_in;
         end
         if (crit_wr_ok) begin
            critical_limit <= limit_crit_in;
         end
         if (wr_capab && w_strb_q[0]) begin
            resolution_capability <= w_data_q[TLEL_CAPAB_RES_LO +: 2];
         end
      end
   end

   // ---------------------------------------------------------------
   // Reading capture
   // ---------------------------------------------------------------
   // Unsupported fraction bits are masked at capture so every read agrees
   wire [12:0] res_mask = (resolution_capability == 2'h0) ? 13'h1FF8 :
                          (resolution_capability == 2'h1) ? 13'h1FFC :
                          (resolution_capability == 2'h2) ? 13'h1FFE : 13'h1FFF;
   wire shutdown = config_reg[TLEL_CFG_SHUTDOWN];
   wire take_sample = sample.valid && !shutdown;
   // Any unlocked limit write reruns the compare
   wire limit_written = alarm_wr_ok || crit_wr_ok;

   assign conv_enable = !shutdown;

   // Reading compared one cycle after it lands
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         temp_value <= 13'h0000;
         eval_pending <= 1'b0;
      end else begin
         if (take_sample) begin
            temp_value <= sample.value & res_mask;
         end
         eval_pending <= take_sample || limit_written;
      end
   end

   // ---------------------------------------------------------------
   // Limit compare with hysteresis
   // ---------------------------------------------------------------
   // Everything widened to 15 bits signed so a 6 C offset cannot wrap at the ends of the range
   wire [1:0] hysteresis_select = config_reg[TLEL_CFG_HYSTERESIS_LO +: 2];
   // Offset in reading steps, zero when off
   wire [14:0] hys_offset = (hysteresis_select == 2'h1) ? TLEL_HYSTERESIS_1P5 :
                            (hysteresis_select == 2'h2) ? TLEL_HYSTERESIS_3 :
                            (hysteresis_select == 2'h3) ? TLEL_HYSTERESIS_6 : 15'h0000;
   // Reading and limits share bit 12 as sign
   wire signed [14:0] t_s = {{2{temp_value[12]}}, temp_value};
   wire signed [14:0] hi_s = {{2{high_limit[12]}}, high_limit[12:0]};
   wire signed [14:0] lo_s = {{2{low_limit[12]}}, low_limit[12:0]};
   wire signed [14:0] cr_s = {{2{critical_limit[12]}}, critical_limit[12:0]};
   wire signed [14:0] hi_rel = hi_s - $signed(hys_offset);
   wire signed [14:0] lo_rel = lo_s + $signed(hys_offset);
   wire signed [14:0] cr_rel = cr_s - $signed(hys_offset);

   // Status bits use the bare limits
   wire flag_crit = t_s >= cr_s;
   wire flag_high = t_s > hi_s;
   wire flag_low = t_s < lo_s;

   // Alert states trip at the limit and release at the limit shifted by the offset
   wire next_above_high = above_high ? (t_s > hi_rel) : (t_s > hi_s);
   wire next_below_low = below_low ? (t_s < lo_rel) : (t_s < lo_s);
   wire next_above_crit = above_crit ? (t_s >= cr_rel) : (t_s >= cr_s);

   // ---------------------------------------------------------------
   // Event decision
   // ---------------------------------------------------------------
   // Mode bits straight from configuration
   wire crit_only = config_reg[TLEL_CFG_CRIT_ONLY];
   wire int_mode = config_reg[TLEL_CFG_MODE];
   // Shutdown halts every evaluation
   wire evaluate = eval_pending && !shutdown;
   // Crossings are changes against the last evaluated states
   wire cross_window = evaluate && !crit_only &&
                       ((next_above_high != above_high) || (next_below_low != below_low));
   // Only entering critical is an event, so leaving it lets a parked clear through
   wire cross_crit = evaluate && next_above_crit && !above_crit;
   wire set_event = cross_window || cross_crit;
   // States as they stand after this cycle
   wire crit_now = evaluate ? next_above_crit : above_crit;
   // Clears count only in interrupt mode
   wire clear_req = wr_config && cfg_in[TLEL_CFG_CLEAR] && int_mode;
   // A clear above critical is parked until the reading falls back
   wire do_clear = (clear_req || clear_pending) && !crit_now;
   // Window state for comparator mode
   wire window_now = evaluate ? (next_above_high || next_below_low) : (above_high || below_low);

   // Mode selection of the alert level
   logic next_alert;
   always_comb begin
      if (crit_only) begin
         next_alert = crit_now;
      end else if (int_mode) begin
         next_alert = crit_now || set_event || (event_latch && !do_clear);
      end else begin
         next_alert = crit_now || window_now;
      end
   end

   // Shutdown freezes the alert except for an explicit clear
   wire alert_hold = shutdown ? (alert_state && !do_clear) : next_alert;

   // Limit states move on evaluation only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         above_high <= 1'b0;
         below_low <= 1'b0;
         above_crit <= 1'b0;
         temp_flags <= 3'h0;
         event_latch <= 1'b0;
         clear_pending <= 1'b0;
         alert_state <= 1'b0;
      end else begin
         if (evaluate) begin
            above_high <= next_above_high;
            below_low <= next_below_low;
            above_crit <= next_above_crit;
            temp_flags <= {flag_crit, flag_high, flag_low};
         end
         // A crossing in the clearing cycle wins over the clear
         // Only interrupt mode records, so no stale event survives a mode change
         event_latch <= int_mode && (set_event || (event_latch && !do_clear));
         clear_pending <= (clear_req || clear_pending) && crit_now && int_mode;
         alert_state <= alert_hold;
      end
   end

   // ---------------------------------------------------------------
   // Open-drain pin
   // ---------------------------------------------------------------
   // Disabled pin floats for active low and is grounded for active high
   wire alert_en = config_reg[TLEL_CFG_EN];
   wire alert_pol = config_reg[TLEL_CFG_POL];
   wire next_drive_low = alert_pol ? !(alert_en && alert_state) : (alert_en && alert_state);

   // Registered so a mode write cannot glitch the pin
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         alert_pin.oe_n <= 1'b1;
         alert_in_q <= 1'b1;
      end else begin
         alert_pin.oe_n <= !next_drive_low;
         alert_in_q <= alert_in;
      end
   end

   // Open drain: the pin is only pulled low
   assign alert_pin.level_out = 1'b0;

   // ---------------------------------------------------------------
   // Read channel
   // ---------------------------------------------------------------
   // Clear bit reads zero; status is the enabled alert
   wire [15:0] cfg_read = {config_reg[15:6], 1'b0, alert_en && alert_state, config_reg[3:0]};
   // Status bits ride above the reading
   wire [15:0] temp_read = {temp_flags, temp_value};
   wire [15:0] capab_read = {10'h000, alert_in_q, resolution_capability, 3'h0};
   wire [15:0] rd_mux = (araddr == TLEL_OFS_CONFIG) ? cfg_read :
                        (araddr == TLEL_OFS_HIGH) ? high_limit :
                        (araddr == TLEL_OFS_LOW) ? low_limit :
                        (araddr == TLEL_OFS_CRIT) ? critical_limit :
                        (araddr == TLEL_OFS_TEMP) ? temp_read :
                        (araddr == TLEL_OFS_CAPAB) ? capab_read : 16'h0000;

   // Read data decoded once, at acceptance
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= TLEL_RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata <= {16'h0000, rd_mux};
         rresp <= is_mapped(araddr) ? TLEL_RESP_OKAY : TLEL_RESP_SLVERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

endmodule

// file: core/tlel_pkg.sv
/*
 * Constants, register map and carrier types of the temperature limit and
 * alert logic. Assumes an AXI4-Lite master with 32-bit data and a sampler
 * that hands over one 13-bit two's complement reading per conversion.
 */
package tlel_pkg;

   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] TLEL_OFS_CONFIG = 8'h00;
   localparam logic [7:0] TLEL_OFS_HIGH = 8'h04;
   localparam logic [7:0] TLEL_OFS_LOW = 8'h08;
   localparam logic [7:0] TLEL_OFS_CRIT = 8'h0C;
   localparam logic [7:0] TLEL_OFS_TEMP = 8'h10;
   localparam logic [7:0] TLEL_OFS_CAPAB = 8'h14;

   // ---------------------------------------------------------------
   // Configuration fields
   // ---------------------------------------------------------------
   localparam int TLEL_CFG_MODE = 0;
   localparam int TLEL_CFG_POL = 1;
   localparam int TLEL_CFG_CRIT_ONLY = 2;
   localparam int TLEL_CFG_EN = 3;
   localparam int TLEL_CFG_STS = 4;
   localparam int TLEL_CFG_CLEAR = 5;
   localparam int TLEL_CFG_ALARM_LOCK = 6;
   localparam int TLEL_CFG_CRIT_LOCK = 7;
   localparam int TLEL_CFG_SHUTDOWN = 8;
   localparam int TLEL_CFG_HYSTERESIS_LO = 9;
   localparam logic [15:0] TLEL_CFG_LOCKED_MASK = 16'h060B;
   localparam logic [15:0] TLEL_CFG_RESET = 16'h0000;
   localparam logic [15:0] TLEL_LIMIT_MASK = 16'h1FFC;
   localparam logic [15:0] TLEL_LIMIT_RESET = 16'h0000;
   localparam logic [1:0] TLEL_RES_RESET = 2'h3;
   localparam int TLEL_CAPAB_RES_LO = 3;
   localparam int TLEL_CAPAB_PIN = 5;

   // Hysteresis offsets in reading steps of 0.0625 C
   localparam logic [14:0] TLEL_HYSTERESIS_1P5 = 15'h0018;
   localparam logic [14:0] TLEL_HYSTERESIS_3 = 15'h0030;
   localparam logic [14:0] TLEL_HYSTERESIS_6 = 15'h0060;

   localparam logic [1:0] TLEL_RESP_OKAY = 2'h0;
   localparam logic [1:0] TLEL_RESP_SLVERR = 2'h2;

   // ---------------------------------------------------------------
   // Carrier types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic [12:0] value;
   } tlel_sample_t;

   typedef struct packed {
      logic level_out;
      logic oe_n;
   } tlel_pin_t;

endpackage

// file: test/tlel_chk.sv
/* Port-level checker of the limit and alert block, bound onto tlel_core.
   Assumes one clock domain and register traffic from the bench. */
`timescale 1ns/1ps
module tlel_chk (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic awvalid,
   input wire logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [7:0] araddr,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   // Sampler and pin
   input wire logic conv_enable,
   input wire tlel_pkg::tlel_pin_t alert_pin
);
   import tlel_pkg::*;
   logic [7:0] rd_a;
   logic [7:0] wr_a;
   logic frz;
   logic [15:0] last_t;
   wire t_rd = rvalid && rready && rd_a == TLEL_OFS_TEMP;
   wire lim_rd = rvalid && rd_a inside {TLEL_OFS_HIGH, TLEL_OFS_LOW, TLEL_OFS_CRIT};
   // Addresses in flight; a reading seen in shutdown arms the freeze check
   always_ff @(posedge aclk) begin
      if (arvalid && arready) rd_a <= araddr;
      if (awvalid && awready) wr_a <= awaddr;
      if (t_rd) last_t <= rdata[15:0];
      frz <= aresetn && !conv_enable && (frz || t_rd);
   end
   default clocking dc @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   lim_low_a: assert property (lim_rd |-> rdata[1:0] == 2'h0)
      else $error("limit low bits set");
   frozen_temp_a: assert property (rvalid && rd_a == TLEL_OFS_TEMP && frz |-> rdata[15:0] == last_t)
      else $error("reading moved in shutdown");
   // Six quiet cycles let a sample or write already in flight land first
   sensor_shutdown_pin_a: assert property ((!conv_enable && !awvalid && !wvalid && !bvalid) [*6] |=> $stable(alert_pin.oe_n))
      else $error("alert moved in shutdown");
   open_drain_a: assert property (!alert_pin.oe_n |-> alert_pin.level_out == 1'b0)
      else $error("alert pin driven high");
   upper_zero_a: assert property (rvalid |-> rdata[31:16] == 16'h0000)
      else $error("upper read half not zero");
   rd_answer_a: assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
   wr_answer_a: assert property (bvalid && bready |=> !bvalid)
      else $error("write response kept");
   unmapped_a: assert property (bvalid && wr_a > TLEL_OFS_CAPAB |-> bresp == TLEL_RESP_SLVERR)
      else $error("unmapped write not refused");
   cover property (t_rd && frz);
   cover property (bvalid && bresp == TLEL_RESP_SLVERR);
   cover property ($fell(alert_pin.oe_n));
endmodule

bind tlel_core tlel_chk u_chk (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .bvalid, .bready, .bresp,
   .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .conv_enable, .alert_pin);

// file: test/tlel_far_model.sv
/* Sampler and pull-up model at the block's far side: one reading per toggle
   of go, and the resolved level of the open-drain alert line. */
`timescale 1ns/1ps
module tlel_far_model (
   // Clock and bench control
   input wire logic aclk,
   input wire logic go,
   input wire logic [12:0] temp,
   // Block side
   input wire tlel_pkg::tlel_pin_t alert_pin,
   output tlel_pkg::tlel_sample_t sample,
   output logic alert_in
);
   import tlel_pkg::*;
   logic go_q = 1'b0;
   initial sample = '0;
   // One valid cycle per toggle; value churns between so a stale one is never trusted
   always @(posedge aclk) begin
      go_q <= go;
      sample.valid <= go != go_q;
      sample.value <= (go != go_q) ? temp : ~sample.value;
   end
   // External pull-up: high unless the block pulls low
   assign alert_in = alert_pin.oe_n ? 1'b1 : alert_pin.level_out;
endmodule

// file: test/temp_limit_event_logic_tb_top.sv
/* Self-checking bench of the limit and alert block: AXI4-Lite register tasks,
   random and corner readings. Assumes the far model and bound checker. */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_fail++; $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module temp_limit_event_logic_tb_top;
   import tlel_pkg::*;
   localparam logic [12:0] HI = 13'h0320;
   localparam logic [12:0] LO = 13'h1E70;
   localparam logic [12:0] CR = 13'h07D0;
   logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
   logic rready = 1'b0, go = 1'b0, awready, wready, bvalid, arready, rvalid, conv_enable, alert_in;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rdata;
   logic [3:0] wstrb = 4'hF;
   logic [12:0] temp = 13'h0000, t;
   logic [15:0] d, d0;
   logic [1:0] r, wr_resp, bresp, rresp;
   logic [12:0] cn [6] = '{CR, CR - 13'h1, HI, HI + 13'h1, LO, LO - 13'h1};
   logic [7:0] la [3] = '{TLEL_OFS_HIGH, TLEL_OFS_LOW, TLEL_OFS_CRIT};
   logic [14:0] hs [3] = '{TLEL_HYSTERESIS_1P5, TLEL_HYSTERESIS_3, TLEL_HYSTERESIS_6};
   tlel_sample_t sample;
   tlel_pin_t alert_pin;
   int n_fail = 0, checks_done = 0, i, seed = 32'h663A4418;
   always #10 aclk = ~aclk;
   tlel_core dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
      .rdata(rdata), .rresp(rresp), .sample(sample), .conv_enable(conv_enable), .alert_in(alert_in),
      .alert_pin(alert_pin));
   tlel_far_model far (.aclk(aclk), .go(go), .temp(temp), .alert_pin(alert_pin), .sample(sample),
      .alert_in(alert_in));
   // ---------------------------------------------------------------
   // Bus tasks and expectations
   // ---------------------------------------------------------------
   // Ready is sampled at the falling edge so the decision matches the rising edge
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      logic ta, tw, bk;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      awaddr <= a;
      wdata <= {16'h0000, v};
      bready <= 1'b1;
      bk = 1'b0;
      while (!bk) begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         bk = bvalid;
         wr_resp = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] v, output logic [1:0] rr);
      logic ta, ok;
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      ok = 1'b0;
      while (!ok) begin
         @(negedge aclk);
         ta = arvalid && arready;
         ok = rvalid;
         v = rdata[15:0];
         rr = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic smp(input logic [12:0] v);
      temp <= v;
      go <= ~go;
      repeat (5) @(posedge aclk);
   endtask
   // Expected pin release level, checked once the pipeline has settled
   task automatic pin(input logic e);
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      `CHK("alert oe_n", e, alert_pin.oe_n)
      @(posedge aclk);
   endtask
   function automatic logic [15:0] tval(input logic [12:0] v, input logic [1:0] res);
      return {$signed(v) >= $signed(CR), $signed(v) > $signed(HI), $signed(v) < $signed(LO), v & ~(13'h0007 >> res)};
   endfunction
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(TLEL_OFS_CAPAB, d, r);
      `CHK("capab reset", 16'h0038, d)
      rd(8'h40, d, r);
      `CHK("unmapped rresp", TLEL_RESP_SLVERR, r)
      wr(8'h40, 16'hFFFF);
      `CHK("unmapped bresp", TLEL_RESP_SLVERR, wr_resp)
      for (i = 0; i < 6; i++) begin
         d0 = (i < 3) ? 16'($random(seed)) : {3'h0, (i == 3) ? HI : (i == 4) ? LO : CR};
         wr(la[i % 3], d0);
         rd(la[i % 3], d, r);
         `CHK("limit", d0 & TLEL_LIMIT_MASK, d)
      end
      $display("test registers done");
      wr(TLEL_OFS_CONFIG, 16'h0008);
      for (i = 0; i < 40; i++) begin
         t = (i < 6) ? cn[i] : 13'($random(seed));
         smp(t);
         d0 = tval(t, 2'h3);
         rd(TLEL_OFS_TEMP, d, r);
         `CHK("temp", d0, d)
         pin(!(d0[14] || d0[13]));
      end
      for (i = 0; i < 4; i++) begin
         wr(TLEL_OFS_CAPAB, {11'h000, 2'(i), 3'h0});
         smp(13'h0FFF);
         rd(TLEL_OFS_TEMP, d, r);
         `CHK("temp res", tval(13'h0FFF, 2'(i)), d)
      end
      smp(HI + 13'h4);
      wr(TLEL_OFS_CONFIG, 16'h0028);
      pin(1'b0);
      smp(13'h0100);
      pin(1'b1);
      wr(TLEL_OFS_HIGH, 16'h00F0);
      pin(1'b0);
      wr(TLEL_OFS_HIGH, {3'h0, HI});
      pin(1'b1);
      $display("test comparator done");
      for (i = 0; i < 3; i++) begin
         wr(TLEL_OFS_CONFIG, {5'h00, 2'(i + 1), 9'h008});
         smp(HI + 13'h4);
         pin(1'b0);
         smp(HI - 13'(hs[i]) + 13'h4);
         pin(1'b0);
         smp(HI - 13'(hs[i]) - 13'h4);
         pin(1'b1);
      end
      wr(TLEL_OFS_CONFIG, 16'h000A);
      pin(1'b0);
      smp(HI + 13'h4);
      pin(1'b1);
      wr(TLEL_OFS_CONFIG, 16'h0000);
      pin(1'b1);
      wr(TLEL_OFS_CONFIG, 16'h000C);
      pin(1'b1);
      smp(CR + 13'h4);
      pin(1'b0);
      smp(13'h0100);
      pin(1'b1);
      $display("test hysteresis polarity critical done");
      wr(TLEL_OFS_CONFIG, 16'h0009);
      pin(1'b1);
      smp(HI + 13'h4);
      pin(1'b0);
      wr(TLEL_OFS_CONFIG, 16'h0029);
      pin(1'b1);
      smp(CR + 13'h4);
      pin(1'b0);
      wr(TLEL_OFS_CONFIG, 16'h0029);
      pin(1'b0);
      smp(HI + 13'h4);
      pin(1'b1);
      $display("test interrupt done");
      wr(TLEL_OFS_CONFIG, 16'h0008);
      pin(1'b0);
      rd(TLEL_OFS_TEMP, d0, r);
      wr(TLEL_OFS_CONFIG, 16'h0108);
      `CHK("conv_enable", 1'b0, conv_enable)
      rd(TLEL_OFS_TEMP, d, r);
      smp(13'h0100);
      rd(TLEL_OFS_TEMP, d, r);
      `CHK("frozen temp", d0, d)
      pin(1'b0);
      rd(TLEL_OFS_CONFIG, d, r);
      `CHK("cfg status", 16'h0118, d)
      wr(TLEL_OFS_CONFIG, 16'h0008);
      smp(13'h0100);
      pin(1'b1);
      $display("test shutdown done");
      end_sim();
   end
   // Watchdog well beyond the thousand or fewer cycles the tests need
   initial begin
      #1000000;
      n_fail++;
      end_sim();
   end
endmodule
